// ==== eqfc_pkg.sv ====
package eqfc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_GCTRL = 8'h00;
  localparam logic [7:0] ADDR_MFCTRL = 8'h04;
  localparam logic [7:0] ADDR_QSTAT = 8'h08;
  localparam logic [7:0] ADDR_ARB = 8'h0c;
  localparam logic [7:0] ADDR_QCFG0 = 8'h10;

  // general_control_register fields (auto is one shared bit, the rest one bit per port from the lsb)
  localparam int GC_AUTO_BIT = 0;
  localparam int GC_JAM_LSB = 8;
  localparam int GC_FDX_LSB = 16;
  localparam int GC_PRC_LSB = 24;

  // mac_flow_ctrl_register fields
  localparam int MF_FCE_LSB = 0;
  localparam int MF_FCB_LSB = 8;
  localparam int MF_TMR_LSB = 16;

  // rx_queue_latched_status fields
  localparam int QS_HIGH_LSB = 0;
  localparam int QS_OVF_LSB = 8;
  localparam int QS_LOW_LSB = 16;

  // per-port queue config: size, high and low threshold, in queue blocks
  localparam int QC_SIZE_LSB = 0;
  localparam int QC_HIGH_LSB = 8;
  localparam int QC_LOW_LSB = 16;

  // reset values
  localparam logic AUTO_FLOW_RST = 1'b1;
  localparam logic [15:0] PAUSE_TMR_RST = 16'h008c;
  localparam logic [15:0] HW_PAUSE_TMR = 16'h008c;
  localparam logic [23:0] QCFG_RST = 24'h000000;

  // bytes jammed at the head of each new frame
  localparam logic [2:0] JAM_BYTES = 3'h4;

  typedef enum logic [0:0] {
    EQFC_JAM_IDLE = 1'b0,
    EQFC_JAM_RUN = 1'b1
  } eqfc_jam_t;

endpackage : eqfc_pkg

// ==== eqfc_flow_ctrl.sv ====
// Overview of operation
// - arbitrate hdlc and mac sdram transfer requests onto one shared sdram
// - half-duplex backpressure jams received frames to provoke far-end collisions
// - full-duplex backpressure sends pause frames carrying a pause timer
// - hardware mode: auto_flow_select_pin enables, full_duplex_select_pin picks pause, timer 140
// - software mode auto_flow_enable is set after reset, host may clear it
// - while auto, device owns enable, busy and jam bits; host writes ignored
// - automatic pause or jam depends only on queue above high threshold
// - low threshold is a status indication only, never a flow decision
// - software full-duplex auto sends pauses with the host timer value
// - in high-threshold state one pause per received frame
// - overflow sets latched flag and refuses new frames while it lasts
// - manual mode host write of busy makes the mac send a pause
// - honour of received pause frames follows pause_respond_control, always on in hardware mode
// - no automatic flow control for the transmit queue
// - half-duplex jam covers the first 4 bytes of each new frame
// - frame in progress at crossing untouched; jam until below threshold
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module eqfc_flow_ctrl #(
  parameter int NUM_PORTS = 4
) (
  input wire logic mclk, // 40 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high = write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic hardware_mode_pin, // high = hardware mode
  input wire logic [NUM_PORTS-1:0] auto_flow_select_pin, // hw mode auto enable
  input wire logic [NUM_PORTS-1:0] full_duplex_select_pin, // hw mode, high = pause
  input wire logic [NUM_PORTS*8-1:0] rx_queue_level, // receive queue fill, blocks
  input wire logic [NUM_PORTS-1:0] rx_frame_start, // pulse, mac sees a new frame
  input wire logic [NUM_PORTS-1:0] rx_byte_strobe, // pulse, one received byte
  input wire logic [NUM_PORTS-1:0] pause_ack, // pulse, mac sent the pause
  input wire logic [2*NUM_PORTS-1:0] sdram_req, // hdlc and mac sdram requests
  output logic [2*NUM_PORTS-1:0] sdram_grant, // one-hot sdram grant
  output logic [NUM_PORTS-1:0] pause_req, // level until pause_ack
  output logic [15:0] pause_timer, // timer field for pause frames
  output logic [NUM_PORTS-1:0] jam_active, // mac replaces bytes with jam
  output logic [NUM_PORTS-1:0] frame_refuse, // drop incoming frames
  output logic [NUM_PORTS-1:0] pause_honour // obey pauses from far end
);

  localparam int NREQ = 2 * NUM_PORTS;
  localparam int PW = 1 + 2 * NUM_PORTS;

  if (NUM_PORTS < 1 || NUM_PORTS > 4)
  begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end

  // pins from outside pass two flops first
  logic [PW-1:0] pin_meta_reg;
  logic [PW-1:0] pin_sync_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= {hardware_mode_pin, full_duplex_select_pin, auto_flow_select_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire hw_mode = pin_sync_reg[PW-1];
  wire [NUM_PORTS-1:0] afcs_s = pin_sync_reg[NUM_PORTS-1:0];
  wire [NUM_PORTS-1:0] fdx_s = pin_sync_reg[2*NUM_PORTS-1:NUM_PORTS];

  // apb slave: one wait state, answer in the second access cycle
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  wire access = psel & penable & ~pready_reg;
  wire fire = psel & penable & pready_reg;
  wire wr_fire = fire & pwrite;
  wire rd_fire = fire & ~pwrite;

  wire hit_gc = (paddr == eqfc_pkg::ADDR_GCTRL);
  wire hit_mf = (paddr == eqfc_pkg::ADDR_MFCTRL);
  wire hit_qs = (paddr == eqfc_pkg::ADDR_QSTAT);
  wire hit_arb = (paddr == eqfc_pkg::ADDR_ARB);
  wire [7:0] qc_off = paddr - eqfc_pkg::ADDR_QCFG0;
  wire hit_qc = (paddr >= eqfc_pkg::ADDR_QCFG0) && (qc_off[1:0] == 2'h0)
    && (qc_off[7:2] < 6'(NUM_PORTS));
  wire hit_any = hit_gc | hit_mf | hit_qs | hit_arb | hit_qc;

  // shared control bits
  logic auto_flow_enable_reg;
  logic [15:0] pause_tmr_reg;
  logic [15:0] pause_timer_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auto_flow_enable_reg <= eqfc_pkg::AUTO_FLOW_RST;
      pause_tmr_reg <= eqfc_pkg::PAUSE_TMR_RST;
      pause_timer_reg <= eqfc_pkg::PAUSE_TMR_RST;
    end
    else
    begin
      if (wr_fire && hit_gc)
        auto_flow_enable_reg <= pwdata[eqfc_pkg::GC_AUTO_BIT];
      if (wr_fire && hit_mf)
        pause_tmr_reg <= pwdata[eqfc_pkg::MF_TMR_LSB +: 16];
      pause_timer_reg <= hw_mode ? eqfc_pkg::HW_PAUSE_TMR : pause_tmr_reg;
    end
  end

  // per-port state gathered for readback
  wire [NUM_PORTS-1:0] jam_rb;
  wire [NUM_PORTS-1:0] fdx_rb;
  wire [NUM_PORTS-1:0] prc_rb;
  wire [NUM_PORTS-1:0] fce_rb;
  wire [NUM_PORTS-1:0] fcb_rb;
  wire [NUM_PORTS-1:0] high_rb;
  wire [NUM_PORTS-1:0] ovf_rb;
  wire [NUM_PORTS-1:0] low_rb;
  wire [23:0] qcfg_rb [NUM_PORTS];

  genvar p;
  for (p = 0; p < NUM_PORTS; p++)
  begin : g_port
    logic jam_reg;
    logic fdx_reg;
    logic prc_reg;
    logic fce_reg;
    logic [23:0] qcfg_reg;
    logic high_reg;
    logic low_reg;
    logic ovf_reg;
    logic refuse_reg;
    logic pause_reg;
    logic honour_reg;
    eqfc_pkg::eqfc_jam_t jam_st_reg;
    logic [2:0] jam_cnt_reg;

    // only the receive queue is watched; transmit queue gets no backpressure
    wire [7:0] level = rx_queue_level[p*8 +: 8];
    wire [7:0] q_size = qcfg_reg[eqfc_pkg::QC_SIZE_LSB +: 8];
    wire [7:0] q_high = qcfg_reg[eqfc_pkg::QC_HIGH_LSB +: 8];
    wire [7:0] q_low = qcfg_reg[eqfc_pkg::QC_LOW_LSB +: 8];
    // threshold equal to size can never be exceeded before overflow
    wire above_high = (level > q_high);
    wire at_full = (level >= q_size);
    wire port_auto = hw_mode ? afcs_s[p] : auto_flow_enable_reg;
    wire port_fdx = hw_mode ? fdx_s[p] : fdx_reg;
    wire host_owns = ~hw_mode & ~auto_flow_enable_reg;
    wire fce_eff = hw_mode ? afcs_s[p] : (auto_flow_enable_reg | fce_reg);
    wire jam_eff = port_auto ? (~port_fdx & high_reg) : (host_owns & jam_reg);
    wire auto_pause = port_auto & port_fdx & high_reg & rx_frame_start[p];
    wire host_pause = host_owns & wr_fire & hit_mf & pwdata[eqfc_pkg::MF_FCB_LSB + p];
    wire pause_set = (auto_pause | host_pause) & fce_eff;
    wire ovf_set = rx_frame_start[p] & at_full;
    wire ovf_clr = rd_fire & hit_qs;
    wire qc_wr = wr_fire & hit_qc & (qc_off[7:2] == 6'(p));
    wire jam_go = (jam_st_reg == eqfc_pkg::EQFC_JAM_IDLE) & rx_frame_start[p] & jam_eff;
    wire jam_last = rx_byte_strobe[p] & (jam_cnt_reg == eqfc_pkg::JAM_BYTES - 3'h1);

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        jam_reg <= 1'b0;
        fdx_reg <= 1'b0;
        prc_reg <= 1'b0;
        fce_reg <= 1'b0;
        qcfg_reg <= eqfc_pkg::QCFG_RST;
      end
      else
      begin
        if (wr_fire && hit_gc && host_owns)
          jam_reg <= pwdata[eqfc_pkg::GC_JAM_LSB + p];
        if (wr_fire && hit_gc)
          fdx_reg <= pwdata[eqfc_pkg::GC_FDX_LSB + p];
        if (wr_fire && hit_gc)
          prc_reg <= pwdata[eqfc_pkg::GC_PRC_LSB + p];
        if (wr_fire && hit_mf && host_owns)
          fce_reg <= pwdata[eqfc_pkg::MF_FCE_LSB + p];
        if (qc_wr)
          qcfg_reg <= pwdata[23:0];
      end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        high_reg <= 1'b0;
        low_reg <= 1'b1;
        ovf_reg <= 1'b0;
        refuse_reg <= 1'b0;
        pause_reg <= 1'b0;
        honour_reg <= 1'b0;
      end
      else
      begin
        high_reg <= above_high;
        low_reg <= (level <= q_low);
        ovf_reg <= ovf_set | (ovf_reg & ~ovf_clr);
        refuse_reg <= at_full;
        pause_reg <= pause_set | (pause_reg & ~pause_ack[p]);
        honour_reg <= hw_mode | prc_reg;
      end
    end

    // jam begins only at a frame start, so the frame under way is spared
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        jam_st_reg <= eqfc_pkg::EQFC_JAM_IDLE;
        jam_cnt_reg <= 3'h0;
      end
      else
      begin
        case (jam_st_reg)
          eqfc_pkg::EQFC_JAM_IDLE:
          begin
            jam_cnt_reg <= 3'h0;
            if (jam_go)
              jam_st_reg <= eqfc_pkg::EQFC_JAM_RUN;
          end
          eqfc_pkg::EQFC_JAM_RUN:
          begin
            if (rx_byte_strobe[p])
              jam_cnt_reg <= jam_cnt_reg + 3'h1;
            if (jam_last)
              jam_st_reg <= eqfc_pkg::EQFC_JAM_IDLE;
          end
          default:
            jam_st_reg <= eqfc_pkg::EQFC_JAM_IDLE;
        endcase
      end
    end

    assign jam_rb[p] = jam_eff;
    assign fdx_rb[p] = port_fdx;
    assign prc_rb[p] = prc_reg;
    assign fce_rb[p] = fce_eff;
    assign fcb_rb[p] = pause_reg;
    assign high_rb[p] = high_reg;
    assign ovf_rb[p] = ovf_reg;
    assign low_rb[p] = low_reg;
    assign qcfg_rb[p] = qcfg_reg;
    assign pause_req[p] = pause_reg;
    assign jam_active[p] = (jam_st_reg == eqfc_pkg::EQFC_JAM_RUN);
    assign frame_refuse[p] = refuse_reg;
    assign pause_honour[p] = honour_reg;
  end

  // sdram arbiter: round robin, grant kept while its request stays up
  logic [NREQ-1:0] grant_reg;
  logic [2:0] last_reg;
  logic [NREQ-1:0] pick;
  logic [2:0] pick_idx;

  always_comb
  begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    pick = '0;
    pick_idx = last_reg;
    for (int i = 1; i <= NREQ; i++)
    begin
      idx = (int'(last_reg) + i) % NREQ;
      if (!found && sdram_req[idx])
      begin
        found = 1'b1;
        pick[idx] = 1'b1;
        pick_idx = 3'(idx);
      end
    end
  end

  wire keep = |(grant_reg & sdram_req);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant_reg <= '0;
      last_reg <= 3'h0;
    end
    else if (!keep)
    begin
      grant_reg <= pick;
      last_reg <= pick_idx;
    end
  end

  assign sdram_grant = grant_reg;

  // read mux; reserved bits read zero
  wire [31:0] rd_gc = 32'(auto_flow_enable_reg) | (32'(jam_rb) << eqfc_pkg::GC_JAM_LSB)
    | (32'(fdx_rb) << eqfc_pkg::GC_FDX_LSB) | (32'(prc_rb) << eqfc_pkg::GC_PRC_LSB);
  wire [31:0] rd_mf = (32'(fce_rb) << eqfc_pkg::MF_FCE_LSB)
    | (32'(fcb_rb) << eqfc_pkg::MF_FCB_LSB) | (32'(pause_tmr_reg) << eqfc_pkg::MF_TMR_LSB);
  wire [31:0] rd_qs = (32'(high_rb) << eqfc_pkg::QS_HIGH_LSB)
    | (32'(ovf_rb) << eqfc_pkg::QS_OVF_LSB) | (32'(low_rb) << eqfc_pkg::QS_LOW_LSB);
  wire [31:0] rd_word = hit_gc ? rd_gc
    : hit_mf ? rd_mf
    : hit_qs ? rd_qs
    : hit_arb ? 32'(grant_reg)
    : hit_qc ? 32'(qcfg_rb[qc_off[3:2]])
    : 32'h00000000;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access & ~hit_any;
      if (access && !pwrite)
        prdata_reg <= rd_word;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pause_timer = pause_timer_reg;

endmodule : eqfc_flow_ctrl

`default_nettype wire

// ==== eqfc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module eqfc_sva #(
  parameter int NUM_PORTS = 4
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic [7:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [31:0] pwdata, // wdata
  input wire logic pready, // ready
  input wire logic hardware_mode_pin, // hw mode
  input wire logic [NUM_PORTS*8-1:0] rx_queue_level, // fill
  input wire logic [NUM_PORTS-1:0] rx_frame_start, // frame
  input wire logic [NUM_PORTS-1:0] rx_byte_strobe, // byte
  input wire logic [NUM_PORTS-1:0] pause_ack, // sent
  input wire logic [2*NUM_PORTS-1:0] sdram_grant, // grant
  input wire logic [NUM_PORTS-1:0] pause_req, // pause
  input wire logic [15:0] pause_timer, // timer
  input wire logic [NUM_PORTS-1:0] jam_active, // jam
  input wire logic [NUM_PORTS-1:0] frame_refuse // refuse
);
  logic [7:0] size0_reg;
  logic [1:0] bytes_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // shadow of port 0 queue size, snooped from completed writes
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      size0_reg <= 8'h00;
      bytes_reg <= 2'h0;
    end
    else
    begin
      if (psel && penable && pready && pwrite && paddr == eqfc_pkg::ADDR_QCFG0)
        size0_reg <= pwdata[7:0];
      bytes_reg <= jam_active[0] ? bytes_reg + 2'(rx_byte_strobe[0]) : 2'h0;
    end
  sequence s_setup;
    psel && !penable;
  endsequence
  chk_apb_one_wait: assert property (s_setup |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  chk_grant_onehot: assert property ($onehot0(sdram_grant))
    else $error("more than one sdram grant");
  chk_pause_hold: assert property (pause_req[0] && !pause_ack[0] |=> pause_req[0])
    else $error("pause request dropped before ack");
  chk_pause_cause: assert property ($rose(pause_req[0]) |->
    $past(rx_frame_start[0]) || $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("pause request without frame or host write");
  chk_jam_cause: assert property ($rose(jam_active[0]) |-> $past(rx_frame_start[0]))
    else $error("jam started without a new frame");
  chk_jam_four: assert property (jam_active[0] && rx_byte_strobe[0] && bytes_reg == 2'h3
    |=> !jam_active[0])
    else $error("jam longer than four bytes");
  chk_jam_hold: assert property (jam_active[0] && !(rx_byte_strobe[0] && bytes_reg == 2'h3)
    |=> jam_active[0])
    else $error("jam shorter than four bytes");
  chk_hw_timer: assert property (hardware_mode_pin [*4] |->
    pause_timer == eqfc_pkg::HW_PAUSE_TMR)
    else $error("hardware mode pause timer wrong");
  chk_refuse_level: assert property ($past(rst_n) |->
    frame_refuse[0] == $past(rx_queue_level[7:0] >= size0_reg))
    else $error("frame refuse does not follow queue overflow");
endmodule : eqfc_sva
bind eqfc_flow_ctrl eqfc_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.*);
`default_nettype wire

// ==== eqfc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module eqfc_mac_model #(
  parameter int NUM_PORTS = 4
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic [NUM_PORTS-1:0] pause_req, // pause wanted
  input wire logic [3:0] ack_dly, // cycles before a pause leaves
  output logic [NUM_PORTS-1:0] rx_frame_start, // frame begins
  output logic [NUM_PORTS-1:0] rx_byte_strobe, // one byte in
  output logic [NUM_PORTS-1:0] pause_ack // pause frame sent
);
  logic [3:0] wait_reg [NUM_PORTS];
  initial
  begin
    rx_frame_start = '0;
    rx_byte_strobe = '0;
  end
  // bytes arrive every other cycle, as from a slow line
  task automatic send_frame(input int p, input int nbytes);
    @(posedge mclk);
    rx_frame_start[p] <= 1'b1;
    @(posedge mclk);
    rx_frame_start[p] <= 1'b0;
    repeat (nbytes)
    begin
      @(posedge mclk);
      rx_byte_strobe[p] <= 1'b1;
      @(posedge mclk);
      rx_byte_strobe[p] <= 1'b0;
    end
  endtask : send_frame
  // a pause waits ack_dly cycles for the transmit side to free up
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      pause_ack <= '0;
      for (int p = 0; p < NUM_PORTS; p++) wait_reg[p] <= 4'h0;
    end
    else
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        pause_ack[p] <= pause_req[p] && !pause_ack[p] && wait_reg[p] == ack_dly;
        wait_reg[p] <= (pause_req[p] && !pause_ack[p]) ? wait_reg[p] + 4'h1 : 4'h0;
      end
endmodule : eqfc_mac_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, hardware_mode_pin, err, jam_d;
  logic [7:0] paddr, sdram_req, sdram_grant, g;
  logic [31:0] pwdata, prdata, rd, rx_queue_level;
  logic [3:0] auto_flow_select_pin, full_duplex_select_pin, rx_frame_start, rx_byte_strobe;
  logic [3:0] pause_ack, pause_req, jam_active, frame_refuse, pause_honour, ack_dly;
  logic [15:0] pause_timer;
  int failures = 0;
  int compares = 0;
  int acks = 0;
  int jams = 0;
  eqfc_flow_ctrl DUT (.*);
  eqfc_mac_model u_mac (.*);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    jam_d <= jam_active[0];
    if (pause_ack[0] === 1'b1) acks++;
    if (jam_active[0] === 1'b1 && jam_d === 1'b0) jams++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic frm(input logic [7:0] lv);
    rx_queue_level[7:0] <= lv;
    repeat (3) @(posedge mclk);
    u_mac.send_frame(0, 6);
    repeat (12) @(posedge mclk);
  endtask : frm
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    print_verdict();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, hardware_mode_pin} = '0;
    {auto_flow_select_pin, full_duplex_select_pin, rx_queue_level, sdram_req, ack_dly} = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h00000001);
    rdchk(8'h04, 32'h008c000f);
    rdchk(8'h08, 32'h000f0000);
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("test reset done");
    apb(1'b1, 8'h10, 32'h00ff0408);
    apb(1'b1, 8'h00, 32'h01010001);
    apb(1'b1, 8'h04, 32'h00c8ff00);
    // timer output is re-registered, so it trails the write by a clock
    repeat (2) @(posedge mclk);
    check({8'h0, pause_req, pause_honour, pause_timer}, 32'h000100c8);
    frm(8'h03);
    check(acks, 0);
    frm(8'h05);
    frm(8'h05);
    check(acks, 2);
    rdchk(8'h08, 32'h000f0001);
    frm(8'h04);
    check(acks, 2);
    $display("test pause done");
    apb(1'b1, 8'h00, 32'h00000001);
    fork
      u_mac.send_frame(0, 8);
      begin
        repeat (4) @(posedge mclk);
        rx_queue_level[7:0] <= 8'h05;
      end
    join
    check(jams, 0);
    frm(8'h05);
    check(jams, 1);
    frm(8'h04);
    check(jams, 1);
    $display("test jam done");
    ack_dly <= 4'h5;
    apb(1'b1, 8'h00, 32'h00010000);
    apb(1'b1, 8'h04, 32'h008c0001);
    apb(1'b1, 8'h04, 32'h008c0101);
    repeat (12) @(posedge mclk);
    check(acks, 3);
    apb(1'b1, 8'h00, 32'h00000100);
    frm(8'h04);
    check(jams, 2);
    $display("test manual done");
    apb(1'b1, 8'h00, 32'h00000000);
    frm(8'h08);
    check({28'h0, frame_refuse}, 32'hf);
    rdchk(8'h08, 32'h000f0101);
    rx_queue_level[7:0] <= 8'h02;
    rdchk(8'h08, 32'h000f0000);
    apb(1'b1, 8'h14, 32'h000868c8);
    rdchk(8'h14, 32'h000868c8);
    $display("test overflow done");
    hardware_mode_pin <= 1'b1;
    auto_flow_select_pin <= 4'h1;
    full_duplex_select_pin <= 4'h1;
    repeat (5) @(posedge mclk);
    check({12'h0, pause_honour, pause_timer}, 32'h000f008c);
    frm(8'h05);
    check(acks, 4);
    full_duplex_select_pin <= 4'h0;
    repeat (5) @(posedge mclk);
    frm(8'h05);
    check(jams, 3);
    check(acks, 4);
    $display("test hardware mode done");
    sdram_req <= 8'h81;
    repeat (3) @(posedge mclk);
    g = sdram_grant;
    // round robin starts after index 0, so the top request wins first
    check({24'h0, g}, 32'h00000080);
    sdram_req <= 8'h01;
    repeat (3) @(posedge mclk);
    check({24'h0, sdram_grant}, 32'h00000001);
    $display("test arbiter done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
